// >>> hw/itcrc_apb_slave.sv
// file: apb slave front end decoding register accesses
`timescale 1ns/1ps
module itcrc_apb_slave (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] rd_word,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic wr_stb,
    output logic rd_stb,
    output logic hit
);
    logic [31:0] next_prdata;
    logic next_pslverr;

    // zero wait state: answer in the first access cycle
    assign pready = psel & penable;
    assign wr_stb = psel & penable & pwrite;
    assign rd_stb = psel & ~penable & ~pwrite;
    assign hit = (paddr == itcrc_pkg::OFF_CTRL_SET) || (paddr == itcrc_pkg::OFF_CTRL_CLR)
        || (paddr == itcrc_pkg::OFF_CMD_PTR) || (paddr == itcrc_pkg::OFF_INT_STATUS)
        || (paddr == itcrc_pkg::OFF_INT_MASK);

    always_comb
    begin
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (psel & ~penable)
        begin
            // data captured in setup so it comes from a flop in the access cycle
            next_prdata = (pwrite | ~hit) ? 32'h0000_0000 : rd_word;
            next_pslverr = ~hit;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end
endmodule : itcrc_apb_slave

// >>> hw/itcrc_pkg.sv
// package: register map, field positions and types for the iso transmit run control block
package itcrc_pkg;
    localparam logic [11:0] OFF_CTRL_SET = 12'h200;
    localparam logic [11:0] OFF_CTRL_CLR = 12'h204;
    localparam logic [11:0] OFF_CMD_PTR = 12'h20C;
    localparam logic [11:0] OFF_INT_STATUS = 12'h210;
    localparam logic [11:0] OFF_INT_MASK = 12'h214;
    localparam int BIT_RUN = 15;
    localparam int BIT_WAKE = 12;
    localparam int BIT_DEAD = 11;
    localparam int BIT_ACTIVE = 10;
    localparam int POS_SPD = 5;
    localparam int POS_EVT = 0;
    localparam logic RST_RUN = 1'b0;
    localparam logic RST_WAKE = 1'b0;
    localparam logic RST_DEAD = 1'b0;
    localparam logic [2:0] RST_SPD = 3'h0;
    localparam logic [4:0] RST_EVT = 5'h00;
    localparam logic [31:0] RST_CMD_PTR = 32'h0000_0000;
    localparam logic [3:0] RST_INT = 4'h0;
    // interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_DEAD = 1;
    localparam int IRQ_START = 2;
    localparam int IRQ_STOP = 3;
    localparam logic [4:0] EVT_ACK_COMPLETE = 5'h11;
    localparam logic [4:0] EVT_DESCRIPTOR_READ = 5'h05;
    localparam logic [4:0] EVT_DATA_READ = 5'h07;
    localparam logic [4:0] EVT_UNKNOWN = 5'h0E;

    typedef enum logic [1:0] {
        ITCRC_IDLE = 2'b00,
        ITCRC_FETCH = 2'b01,
        ITCRC_WAIT = 2'b10,
        ITCRC_PROC = 2'b11
    } itcrc_state_e;

    // one descriptor-side report from the dma datapath
    typedef struct packed {
        logic fetch_done;
        logic last_done;
        logic fatal;
        logic list_end;
        logic [4:0] evt_code;
    } itcrc_report_s;
endpackage : itcrc_pkg

// >>> hw/itcrc_run_control.sv
// file: isochronous transmit context run control and status
// Notes on behaviour
// - hardware changes run only on reset
// - bits 14 and 13 read zero
// - wake cleared on every descriptor fetch; a software set of wake in the same cycle keeps it set
// - dead set on fatal processing error
// - dead held until run cleared
// - active reads one while processing descriptors
// - bits 9 and 8 read zero
// - speed field meaningless for transmit
// - completion code written after last descriptor
// - set and clear write addresses
// - run start fetches at command pointer
`timescale 1ns/1ps
module itcrc_run_control (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire itcrc_pkg::itcrc_report_s report,
    input wire logic fetch_ready,
    output logic fetch_req,
    output logic [31:0] fetch_addr,
    output logic irq
);
    logic run;
    logic wake;
    logic dead;
    logic [2:0] spd;
    logic [4:0] evt;
    logic [31:0] cmd_ptr;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    itcrc_pkg::itcrc_state_e state;
    logic next_run;
    logic next_wake;
    logic next_dead;
    logic [2:0] next_spd;
    logic [4:0] next_evt;
    logic [31:0] next_cmd_ptr;
    logic [3:0] next_int_status;
    logic [3:0] next_int_mask;
    itcrc_pkg::itcrc_state_e next_state;
    logic [31:0] rd_word;
    logic [31:0] ctrl_word;
    logic wr_stb;
    logic hit;
    logic active;
    logic [3:0] int_events;
    logic wr_set;
    logic wr_clr;
    logic halt;
    logic int_w1c;

    itcrc_apb_slave u_apb (
        .clk(clk),
        .arst_n(arst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .rd_word(rd_word),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .wr_stb(wr_stb),
        .rd_stb(),
        .hit(hit)
    );

    assign wr_set = wr_stb && (paddr == itcrc_pkg::OFF_CTRL_SET);
    assign wr_clr = wr_stb && (paddr == itcrc_pkg::OFF_CTRL_CLR);

    // active follows the state, never a separate flop that could drift; a list-end wait is not processing
    always_comb
    begin
        case (state)
            itcrc_pkg::ITCRC_FETCH: active = 1'b1;
            itcrc_pkg::ITCRC_PROC: active = 1'b1;
            default: active = 1'b0;
        endcase
    end

    // stop request shared by both sequencer overrides
    assign halt = !run || dead || soft_reset;

    always_comb
    begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[itcrc_pkg::BIT_RUN] = run;
        ctrl_word[itcrc_pkg::BIT_WAKE] = wake;
        ctrl_word[itcrc_pkg::BIT_DEAD] = dead;
        ctrl_word[itcrc_pkg::BIT_ACTIVE] = active;
        ctrl_word[itcrc_pkg::POS_SPD +: 3] = spd;
        ctrl_word[itcrc_pkg::POS_EVT +: 5] = evt;
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (paddr)
            itcrc_pkg::OFF_CTRL_SET: rd_word = ctrl_word;
            itcrc_pkg::OFF_CTRL_CLR: rd_word = ctrl_word;
            itcrc_pkg::OFF_CMD_PTR: rd_word = cmd_ptr;
            itcrc_pkg::OFF_INT_STATUS: rd_word = {28'h0000000, int_status};
            itcrc_pkg::OFF_INT_MASK: rd_word = {28'h0000000, int_mask};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // run and wake: only software writes and resets touch run
    always_comb
    begin
        next_run = run;
        next_wake = wake;
        if (wr_set && pwdata[itcrc_pkg::BIT_RUN])
        begin
            next_run = 1'b1;
        end
        if (wr_clr && pwdata[itcrc_pkg::BIT_RUN])
        begin
            next_run = 1'b0;
        end
        if (wr_clr && pwdata[itcrc_pkg::BIT_WAKE])
        begin
            next_wake = 1'b0;
        end
        // a fetch clears wake, but a same-cycle software set wins
        if (report.fetch_done)
        begin
            next_wake = 1'b0;
        end
        if (wr_set && pwdata[itcrc_pkg::BIT_WAKE])
        begin
            next_wake = 1'b1;
        end
        if (soft_reset)
        begin
            next_run = itcrc_pkg::RST_RUN;
            next_wake = itcrc_pkg::RST_WAKE;
        end
    end

    // sequencer
    always_comb
    begin
        next_state = state;
        fetch_req = 1'b0;
        case (state)
            itcrc_pkg::ITCRC_IDLE:
            begin
                if (run && !dead)
                begin
                    next_state = itcrc_pkg::ITCRC_FETCH;
                end
            end
            itcrc_pkg::ITCRC_FETCH:
            begin
                fetch_req = 1'b1;
                if (fetch_ready)
                begin
                    next_state = itcrc_pkg::ITCRC_PROC;
                end
            end
            itcrc_pkg::ITCRC_PROC:
            begin
                if (report.list_end)
                begin
                    next_state = itcrc_pkg::ITCRC_WAIT;
                end
                else if (report.last_done)
                begin
                    next_state = itcrc_pkg::ITCRC_FETCH;
                end
            end
            itcrc_pkg::ITCRC_WAIT:
            begin
                // stalled at list end; wake resumes from the command pointer
                if (wake)
                begin
                    next_state = itcrc_pkg::ITCRC_FETCH;
                end
            end
            default: next_state = itcrc_pkg::ITCRC_IDLE;
        endcase
        if (halt || report.fatal)
        begin
            next_state = itcrc_pkg::ITCRC_IDLE;
        end
        if (state == itcrc_pkg::ITCRC_WAIT && !wake)
        begin
            next_state = halt ? itcrc_pkg::ITCRC_IDLE : itcrc_pkg::ITCRC_WAIT;
        end
    end

    // status fields and command pointer
    always_comb
    begin
        next_dead = dead;
        next_evt = evt;
        next_spd = spd;
        next_cmd_ptr = cmd_ptr;
        if (active && report.fatal)
        begin
            next_dead = 1'b1;
        end
        else if (!run)
        begin
            next_dead = 1'b0;
        end
        if (active && report.last_done)
        begin
            next_evt = report.evt_code;
        end
        if (wr_set && (paddr == itcrc_pkg::OFF_CTRL_SET) && !run)
        begin
            next_cmd_ptr = cmd_ptr;
        end
        if (wr_stb && (paddr == itcrc_pkg::OFF_CMD_PTR) && !run)
        begin
            // pointer loadable only while stopped
            next_cmd_ptr = pwdata;
        end
        if (soft_reset)
        begin
            next_dead = itcrc_pkg::RST_DEAD;
            next_evt = itcrc_pkg::RST_EVT;
            next_spd = itcrc_pkg::RST_SPD;
        end
    end

    assign fetch_addr = cmd_ptr;

    // interrupts: set wins over write-one-to-clear
    assign int_events[itcrc_pkg::IRQ_DONE] = active && report.last_done;
    assign int_events[itcrc_pkg::IRQ_DEAD] = active && report.fatal;
    assign int_events[itcrc_pkg::IRQ_START] = (state == itcrc_pkg::ITCRC_IDLE)
        && (next_state != itcrc_pkg::ITCRC_IDLE);
    assign int_events[itcrc_pkg::IRQ_STOP] = active && (next_state == itcrc_pkg::ITCRC_IDLE);

    assign int_w1c = wr_stb && (paddr == itcrc_pkg::OFF_INT_STATUS);

    // per-bit sticky status; an event in the clearing cycle must not be lost
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_int_bit
            assign next_int_status[gi] = (int_status[gi] & ~(int_w1c & pwdata[gi])) | int_events[gi];
        end
    endgenerate

    always_comb
    begin
        next_int_mask = int_mask;
        if (wr_stb && (paddr == itcrc_pkg::OFF_INT_MASK))
        begin
            next_int_mask = pwdata[3:0];
        end
    end

    assign irq = |(int_status & int_mask);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            run <= itcrc_pkg::RST_RUN;
            wake <= itcrc_pkg::RST_WAKE;
            dead <= itcrc_pkg::RST_DEAD;
            spd <= itcrc_pkg::RST_SPD;
            evt <= itcrc_pkg::RST_EVT;
            cmd_ptr <= itcrc_pkg::RST_CMD_PTR;
            int_status <= itcrc_pkg::RST_INT;
            int_mask <= itcrc_pkg::RST_INT;
            state <= itcrc_pkg::ITCRC_IDLE;
        end
        else
        begin
            run <= next_run;
            wake <= next_wake;
            dead <= next_dead;
            spd <= next_spd;
            evt <= next_evt;
            cmd_ptr <= next_cmd_ptr;
            int_status <= next_int_status;
            int_mask <= next_int_mask;
            state <= next_state;
        end
    end
endmodule : itcrc_run_control

// >>> verification/itcrc_datapath_model.sv
// partner: descriptor datapath answering fetches after a random stall
`timescale 1ns/1ps
module itcrc_datapath_model (
    input wire logic clk,
    input wire logic fetch_req,
    input wire logic [2:0] cmd,
    input wire logic [4:0] code,
    output logic fetch_ready,
    output itcrc_pkg::itcrc_report_s report
);
    int cnt = 0;
    int lim = 6;
    logic [4:0] noise = 5'h00;
    initial fetch_ready = 1'b0;
    always @(posedge clk)
    begin
        fetch_ready <= fetch_req && !fetch_ready && cnt >= lim;
        cnt <= fetch_req && !fetch_ready ? cnt + 1 : 0;
        lim <= fetch_ready ? $urandom_range(9, 6) : lim;
        noise <= 5'($urandom);
    end
    // code is junk outside a completion so nothing can lean on it
    assign report = '{fetch_req && fetch_ready, cmd[0], cmd[1], cmd[2], cmd[0] ? code : noise};
endmodule : itcrc_datapath_model

// >>> verification/itcrc_properties.sv
// checker: port level properties of the run control block
`timescale 1ns/1ps
module itcrc_properties (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic soft_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire itcrc_pkg::itcrc_report_s report,
    input wire logic fetch_ready,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    input wire logic irq
);
    logic acc, ctl, hit, ws, wc, run_m, wake_m, next_run_m, next_wake_m;
    assign acc = psel && penable;
    assign ctl = paddr == itcrc_pkg::OFF_CTRL_SET || paddr == itcrc_pkg::OFF_CTRL_CLR;
    assign hit = ctl || paddr inside {itcrc_pkg::OFF_CMD_PTR, itcrc_pkg::OFF_INT_STATUS, itcrc_pkg::OFF_INT_MASK};
    assign ws = acc && pwrite && paddr == itcrc_pkg::OFF_CTRL_SET;
    assign wc = acc && pwrite && paddr == itcrc_pkg::OFF_CTRL_CLR;
    // shadow of software bits; a set beats a fetch clear in the same cycle
    always_comb
    begin
        next_run_m = (run_m || (ws && pwdata[15])) && !(wc && pwdata[15]) && !soft_reset;
        next_wake_m = ((wake_m && !report.fetch_done) || (ws && pwdata[12])) && !(wc && pwdata[12]) && !soft_reset;
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            run_m <= 1'b0;
            wake_m <= 1'b0;
        end
        else
        begin
            run_m <= next_run_m;
            wake_m <= next_wake_m;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_rd_ctl;
        acc && !pwrite && ctl;
    endsequence
    sequence s_run_rise;
        !run_m && next_run_m;
    endsequence
    sequence s_no_abort;
        !soft_reset && !report.fatal;
    endsequence
    a_ready_zero_wait: assert property (acc |-> pready) else $error("pready late");
    a_rsvd_high_zero: assert property (s_rd_ctl |-> {prdata[31:16], prdata[14:13]} == 18'h0)
        else $error("bits 14 13 set");
    a_rsvd_low_zero: assert property (s_rd_ctl |-> prdata[9:5] == 5'h00) else $error("bits 9 to 5 set");
    a_run_sw_only: assert property (s_rd_ctl |-> prdata[15] == $past(run_m)) else $error("run moved");
    a_wake_fetch_clr: assert property (s_rd_ctl |-> prdata[12] == $past(wake_m)) else $error("wake wrong");
    a_start_fetch: assert property (s_run_rise ##1 s_no_abort |=> fetch_req) else $error("no fetch");
    a_fetch_holds: assert property (fetch_req && !fetch_ready && next_run_m && !report.fatal |=> fetch_req)
        else $error("fetch dropped");
    a_stop_no_fetch: assert property (!run_m && !$past(run_m) |-> !fetch_req) else $error("fetch stopped");
    a_addr_decode: assert property (acc |-> pslverr == !hit && (pwrite || hit || prdata == 32'h0))
        else $error("decode wrong");
endmodule : itcrc_properties
bind itcrc_run_control itcrc_properties chk_u (.clk(clk), .arst_n(arst_n), .soft_reset(soft_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .report(report), .fetch_ready(fetch_ready),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .irq(irq));

// >>> verification/itcrc_run_control_tb.sv
// testbench: run control, status, event code and interrupt checks
`timescale 1ns/1ps
module itcrc_run_control_tb;
    localparam logic [11:0] ST = itcrc_pkg::OFF_CTRL_SET;
    localparam logic [11:0] CL = itcrc_pkg::OFF_CTRL_CLR;
    logic clk, arst_n, soft_reset, psel, penable, pwrite, pready, pslverr, fetch_ready, fetch_req, irq, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, fetch_addr, rdat, ptr;
    logic [2:0] cmd;
    logic [4:0] code;
    itcrc_pkg::itcrc_report_s report;
    int n_mismatch, check_count;
    logic [4:0] codes [4] = '{itcrc_pkg::EVT_ACK_COMPLETE, itcrc_pkg::EVT_DESCRIPTOR_READ,
        itcrc_pkg::EVT_DATA_READ, itcrc_pkg::EVT_UNKNOWN};
    itcrc_run_control dut_u (.clk(clk), .arst_n(arst_n), .soft_reset(soft_reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .report(report), .fetch_ready(fetch_ready),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .irq(irq));
    itcrc_datapath_model dp_u (.clk(clk), .fetch_req(fetch_req), .cmd(cmd), .code(code),
        .fetch_ready(fetch_ready), .report(report));
    function automatic logic [31:0] cw(input logic run, wake, dead, act, input logic [4:0] evt);
        return {16'h0, run, 2'b00, wake, dead, act, 5'h00, evt};
    endfunction : cw
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // wait for the fetch handshake, checking where it points
    task automatic wf;
        while (!(fetch_req === 1'b1 && fetch_ready === 1'b1)) @(posedge clk);
        chk(fetch_addr, ptr);
        @(posedge clk);
    endtask : wf
    task automatic pulse(input logic [2:0] c, input logic [4:0] k);
        cmd <= c;
        code <= k;
        @(posedge clk);
        cmd <= 3'h0;
        @(posedge clk);
    endtask : pulse
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        {arst_n, soft_reset, psel, penable, pwrite, paddr, pwdata, cmd, code} = '0;
        n_mismatch = 0;
        check_count = 0;
        void'($urandom(32'h755d69ff));
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        apb(0, ST, 32'h0);
        chk(rdat, cw(0, 0, 0, 0, itcrc_pkg::RST_EVT));
        apb(0, 12'h3FC, 32'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        ptr = $urandom;
        apb(1, itcrc_pkg::OFF_CMD_PTR, ptr);
        apb(1, itcrc_pkg::OFF_INT_MASK, 32'h0);
        apb(1, ST, ($urandom & 32'hFFFF_6FFF) | 32'h8000);
        wf();
        apb(0, CL, 32'h0);
        chk(rdat, cw(1, 0, 0, 1, itcrc_pkg::RST_EVT));
        apb(1, itcrc_pkg::OFF_CMD_PTR, ~ptr);
        foreach (codes[i])
        begin
            pulse(3'b001, codes[i]);
            apb(0, ST, 32'h0);
            chk(rdat, cw(1, 0, 0, 1, codes[i]));
            wf();
        end
        chk(32'(irq), 32'h0);
        apb(1, itcrc_pkg::OFF_INT_MASK, 32'h1 << itcrc_pkg::IRQ_DONE);
        chk(32'(irq), 32'h1);
        apb(1, itcrc_pkg::OFF_INT_STATUS, 32'hF);
        apb(0, itcrc_pkg::OFF_INT_STATUS, 32'h0);
        chk(rdat, 32'h0);
        chk(32'(irq), 32'h0);
        apb(1, ST, 32'h1000);
        apb(0, ST, 32'h0);
        chk(rdat, cw(1, 1, 0, 1, codes[3]));
        pulse(3'b100, 5'h00);
        wf();
        apb(0, ST, 32'h0);
        chk(rdat, cw(1, 0, 0, 1, codes[3]));
        pulse(3'b100, 5'h00);
        apb(0, ST, 32'h0);
        chk(rdat, cw(1, 0, 0, 0, codes[3]));
        apb(1, ST, 32'h1000);
        wf();
        pulse(3'b010, 5'h00);
        apb(0, ST, 32'h0);
        chk(rdat, cw(1, 0, 1, 0, codes[3]));
        apb(0, itcrc_pkg::OFF_INT_STATUS, 32'h0);
        chk(rdat, (32'h1 << itcrc_pkg::IRQ_DEAD) | (32'h1 << itcrc_pkg::IRQ_STOP));
        apb(1, CL, 32'h8000);
        apb(0, CL, 32'h0);
        chk(rdat, cw(0, 0, 0, 0, codes[3]));
        apb(1, ST, 32'h8000);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        apb(0, ST, 32'h0);
        chk(rdat, cw(0, 0, 0, 0, itcrc_pkg::RST_EVT));
        print_verdict();
    end
endmodule : itcrc_run_control_tb
